//--- pkg/dpram_ctl_map.vh
// timing counts and field constants for the dual-port ram port controller
`ifndef DPRAM_CTL_MAP_VH
`define DPRAM_CTL_MAP_VH

`define CLK_PERIOD_NS 10
// write-cycle minimums in ns (fastest grade)
`define T_WRITE_CYCLE_NS 15
`define T_ENABLE_TO_END_NS 12
`define T_ADDR_SETUP_NS 0
`define T_WRITE_PULSE_NS 12
`define T_WRITE_RECOVERY_NS 0
`define T_WRITE_DATA_SETUP_NS 10
`define T_WRITE_TO_HIZ_NS 10
`define T_WRITE_DATA_HOLD_NS 0
`define T_FLAG_WRITE_TO_READ_NS 5
`define T_FLAG_CONTENTION_NS 5
// read-side maxima in ns
`define T_ADDR_ACCESS_NS 15
`define T_ENABLE_ACCESS_NS 15
`define T_OE_ACCESS_NS 10
`define T_BUSY_RELEASE_TO_DATA_NS 18
`define T_OUTPUT_HIZ_NS 10

// op codes on i_op
`define OP_RAM_READ 2'h0
`define OP_RAM_WRITE 2'h1
`define OP_FLAG_READ 2'h2
`define OP_FLAG_WRITE 2'h3

`endif

//--- hdl/phase_timer.v
// down counter that measures one bus phase in whole clock cycles
`timescale 1ns/100ps
`default_nettype none

module phase_timer #(
   parameter W = 4
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_load,
   input wire [W-1:0] i_count,
   output wire o_done
);

   reg [W-1:0] cnt_r;

   always @(posedge i_clk) begin
      if (i_rst) begin
         cnt_r <= {W{1'b0}};
      end else if (i_load) begin
         cnt_r <= i_count;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end

   // done while the count sits at zero; a load term here would loop through the caller
   assign o_done = (cnt_r == {W{1'b0}});

endmodule // phase_timer

`default_nettype wire

//--- hdl/dpram_port_ctl.v
// host-side sequencer driving one port of an asynchronous dual-port static ram
`timescale 1ns/100ps
`default_nettype none
`include "dpram_ctl_map.vh"

module dpram_port_ctl #(
   parameter AW = 15,
   parameter DW = 8
) (
   input wire i_clk,
   input wire i_rst,
   // user side
   input wire i_req,
   input wire [1:0] i_op,
   input wire [AW-1:0] i_addr,
   input wire [DW-1:0] i_wdata,
   input wire i_busy_wait,
   output wire o_ready,
   output reg [DW-1:0] o_rdata,
   output reg o_rvalid,
   output wire o_done,
   // device pins
   output reg o_chip_sel_n,
   output reg o_flag_select_n,
   output reg o_rw_n,
   output reg o_out_en_n,
   output reg [AW-1:0] o_addr,
   input wire [DW-1:0] i_data,
   output reg [DW-1:0] o_data,
   output reg o_data_oe
);

   // ====================================================================
   // cycle counts
   // ====================================================================
   // least times round up, never below one cycle
   function [3:0] ceil_cyc;
      input integer ns;
      integer c;
      begin
         c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
         if (c < 1) begin
            c = 1;
         end
         ceil_cyc = c[3:0];
      end
   endfunction

   function integer max2;
      input integer a;
      input integer b;
      begin
         max2 = (a > b) ? a : b;
      end
   endfunction

   // strobe low: larger of pulse width, enable to end, and turnoff plus data setup
   localparam [3:0] WP_CYC = ceil_cyc(max2(max2(`T_WRITE_PULSE_NS, `T_ENABLE_TO_END_NS),
      `T_WRITE_TO_HIZ_NS + `T_WRITE_DATA_SETUP_NS));
   localparam [3:0] HOLD_CYC = ceil_cyc(`T_WRITE_DATA_HOLD_NS);
   localparam [3:0] REC_CYC = ceil_cyc(max2(`T_WRITE_CYCLE_NS - max2(`T_WRITE_PULSE_NS,
      `T_WRITE_TO_HIZ_NS + `T_WRITE_DATA_SETUP_NS), `T_WRITE_RECOVERY_NS));
   localparam [3:0] RD_CYC = ceil_cyc(max2(max2(`T_ADDR_ACCESS_NS, `T_ENABLE_ACCESS_NS),
      `T_OE_ACCESS_NS));
   localparam [3:0] BDD_CYC = ceil_cyc(`T_BUSY_RELEASE_TO_DATA_NS);
   localparam [3:0] FLAG_GAP_CYC = ceil_cyc(max2(`T_FLAG_WRITE_TO_READ_NS,
      `T_FLAG_CONTENTION_NS));
   localparam [3:0] RD_HIZ_CYC = ceil_cyc(`T_OUTPUT_HIZ_NS);

   // ====================================================================
   // sequencer
   // ====================================================================
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_SETUP = 3'h1;
   localparam [2:0] S_WPULSE = 3'h2;
   localparam [2:0] S_WHOLD = 3'h3;
   localparam [2:0] S_RACCESS = 3'h4;
   localparam [2:0] S_RBUSY = 3'h5;
   localparam [2:0] S_RECOVER = 3'h6;

   reg [2:0] state_r;
   reg is_wr_r;
   reg is_flag_r;
   reg load;
   reg [3:0] load_cnt;
   wire t_done;

   phase_timer #(.W(4)) u_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(load),
      .i_count(load_cnt),
      .o_done(t_done)
   );

   // requests accepted only from idle; flag read after flag write waits out the gap
   assign o_ready = (state_r == S_IDLE) && t_done;
   assign o_done = o_rvalid;

   always @* begin
      load = 1'b0;
      load_cnt = 4'h0;
      case (state_r)
         S_IDLE: begin
            if (i_req && o_ready) begin
               load = 1'b1;
               load_cnt = 4'h1;
            end
         end
         S_SETUP: begin
            if (t_done) begin
               load = 1'b1;
               // load the full pulse or access count; the two setup cycles spent with outputs off are not subtracted
               load_cnt = is_wr_r ? WP_CYC : RD_CYC;
            end
         end
         S_WPULSE: begin
            if (t_done) begin
               load = 1'b1;
               load_cnt = HOLD_CYC;
            end
         end
         S_WHOLD: begin
            if (t_done) begin
               load = 1'b1;
               load_cnt = is_flag_r ? FLAG_GAP_CYC : REC_CYC;
            end
         end
         S_RACCESS: begin
            if (t_done && i_busy_wait) begin
               load = 1'b1;
               load_cnt = BDD_CYC;
            end else if (t_done) begin
               load = 1'b1;
               load_cnt = RD_HIZ_CYC;
            end
         end
         S_RBUSY: begin
            if (t_done && !i_busy_wait) begin
               load = 1'b1;
               load_cnt = BDD_CYC;
            end else if (t_done) begin
               load = 1'b1;
               load_cnt = 4'h1;
            end
         end
         default: begin
            load = 1'b0;
         end
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= S_IDLE;
         is_wr_r <= 1'b0;
         is_flag_r <= 1'b0;
         o_chip_sel_n <= 1'b1;
         o_flag_select_n <= 1'b1;
         o_rw_n <= 1'b1;
         o_out_en_n <= 1'b1;
         o_addr <= {AW{1'b0}};
         o_data <= {DW{1'b0}};
         o_data_oe <= 1'b0;
         o_rdata <= {DW{1'b0}};
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (i_req && o_ready) begin
                  // address moves only while both select and strobe are high
                  o_addr <= i_addr;
                  o_data <= i_wdata;
                  is_wr_r <= i_op[0];
                  is_flag_r <= i_op[1];
                  state_r <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (t_done) begin
                  // ram: chip low flag high; flag: chip high flag low
                  o_chip_sel_n <= is_flag_r;
                  o_flag_select_n <= ~is_flag_r;
                  if (is_wr_r) begin
                     // strobe falls with select so device outputs stay off
                     o_rw_n <= 1'b0;
                     o_out_en_n <= 1'b1;
                     // outputs already off: enable off and strobe with select
                     o_data_oe <= 1'b1;
                     state_r <= S_WPULSE;
                  end else begin
                     o_out_en_n <= 1'b0;
                     state_r <= S_RACCESS;
                  end
               end
            end
            S_WPULSE: begin
               if (t_done) begin
                  // strobe rises first so it alone ends the write
                  o_rw_n <= 1'b1;
                  state_r <= S_WHOLD;
               end
            end
            S_WHOLD: begin
               if (t_done) begin
                  // data released only after the hold past write end
                  o_data_oe <= 1'b0;
                  o_chip_sel_n <= 1'b1;
                  o_flag_select_n <= 1'b1;
                  o_rvalid <= 1'b1;
                  state_r <= S_RECOVER;
               end
            end
            S_RACCESS: begin
               if (t_done) begin
                  if (i_busy_wait) begin
                     // opposite port finishing a write here: extra wait
                     state_r <= S_RBUSY;
                  end else begin
                     o_rdata <= i_data;
                     o_rvalid <= 1'b1;
                     o_out_en_n <= 1'b1;
                     o_chip_sel_n <= 1'b1;
                     o_flag_select_n <= 1'b1;
                     state_r <= S_RECOVER;
                  end
               end
            end
            S_RBUSY: begin
               if (t_done && !i_busy_wait) begin
                  state_r <= S_RACCESS;
               end
            end
            S_RECOVER: begin
               // counted gap before the next phase may start
               if (t_done) begin
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule // dpram_port_ctl

`default_nettype wire

//--- test/dpram_port_ctl_asserts.sv
// pin-level checker for the dual-port ram port sequencer
`timescale 1ns/100ps
`default_nettype none
module dpram_port_ctl_asserts #(parameter AW = 15, parameter DW = 8) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic o_chip_sel_n,
   input wire logic o_flag_select_n,
   input wire logic o_rw_n,
   input wire logic o_out_en_n,
   input wire logic [AW-1:0] o_addr,
   input wire logic [DW-1:0] o_data,
   input wire logic o_data_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence wr_pulse;
      !o_rw_n [*3] ##1 o_rw_n;
   endsequence
   sequence sel_one;
      o_chip_sel_n != o_flag_select_n;
   endsequence
   a_one_select:
      assert property (!o_rw_n |-> sel_one) else $error("write without single select");
   a_sel_stable:
      assert property (!o_rw_n && !$past(o_rw_n) |-> $stable({o_chip_sel_n, o_flag_select_n}))
         else $error("select moved in write");
   a_addr_move:
      assert property (!$stable(o_addr) |-> (o_rw_n || o_chip_sel_n) &&
         ($past(o_rw_n) || $past(o_chip_sel_n)))
         else $error("address moved while enabled");
   a_pulse_len:
      assert property ($fell(o_rw_n) |-> wr_pulse) else $error("write pulse length");
   a_no_fight:
      assert property (o_data_oe |-> o_out_en_n && $past(o_out_en_n)) else $error("data fight");
   a_data_hold:
      assert property ($rose(o_rw_n) |-> o_data_oe && $stable(o_data)) else $error("data hold");
   a_flag_cs:
      assert property (!o_flag_select_n || !$past(o_flag_select_n) |-> o_chip_sel_n)
         else $error("chip select low in flag access");
   a_flag_gap:
      assert property ($rose(o_flag_select_n) |=> o_flag_select_n) else $error("flag gap");
endmodule // dpram_port_ctl_asserts
bind dpram_port_ctl dpram_port_ctl_asserts #(.AW(AW), .DW(DW)) chk (.i_clk(i_clk), .i_rst(i_rst),
   .o_chip_sel_n(o_chip_sel_n), .o_flag_select_n(o_flag_select_n), .o_rw_n(o_rw_n),
   .o_out_en_n(o_out_en_n), .o_addr(o_addr), .o_data(o_data), .o_data_oe(o_data_oe));
`default_nettype wire

//--- test/dpram_port_model.sv
// behavioural model of one ram port as seen from its pins
`timescale 1ns/100ps
`default_nettype none
module dpram_port_model (
   input wire logic i_clk,
   input wire logic i_cs_n,
   input wire logic i_flag_n,
   input wire logic i_rw_n,
   input wire logic i_oe_n,
   input wire logic [14:0] i_addr,
   input wire logic [7:0] i_wd,
   output logic [7:0] o_q
);
   logic [7:0] mem [0:32767];
   logic [7:0] flag;
   logic [7:0] last = 8'h00;
   wire rd = !i_oe_n && i_rw_n && (!i_cs_n || !i_flag_n);
   wire [7:0] v = !i_cs_n ? mem[i_addr] : {7'h0, flag[i_addr[2:0]]};
   // last overlap cycle wins, so data counts at the end of the write
   always @(posedge i_clk) begin
      if (!i_rw_n && !i_cs_n) mem[i_addr] <= i_wd;
      if (!i_rw_n && !i_flag_n) flag[i_addr[2:0]] <= i_wd[0];
      if (rd) last <= v;
   end
   // released pins show the inverse so stale data cannot pass
   assign #12 o_q = rd ? v : ~last;
endmodule // dpram_port_model
`default_nettype wire

//--- test/dual_port_ram_write_cycle_tb_top.sv
// self-checking bench for the dual-port ram port sequencer
`timescale 1ns/100ps
`default_nettype none
`include "dpram_ctl_map.vh"
module dual_port_ram_write_cycle_tb_top;
   logic i_clk, i_rst, i_req, i_busy_wait;
   logic [1:0] i_op;
   logic [14:0] i_addr;
   logic [7:0] i_wdata;
   wire o_ready, o_rvalid, o_done, o_chip_sel_n, o_flag_select_n, o_rw_n, o_out_en_n, o_data_oe;
   wire [14:0] o_addr;
   wire [7:0] o_rdata, o_data, dev_q;
   // released host lines show the inverse of their value
   wire [7:0] wd = o_data_oe ? o_data : ~o_data;
   integer bad_count = 0;
   integer n_checks = 0;
   integer i, cyc;
   logic [32:0] rows [0:7] = '{{`OP_RAM_WRITE, 15'h0001, 8'h5a, 8'h00},
      {`OP_RAM_WRITE, 15'h7fff, 8'ha5, 8'h00}, {`OP_RAM_READ, 15'h0001, 8'h00, 8'h5a},
      {`OP_RAM_READ, 15'h7fff, 8'h00, 8'ha5}, {`OP_FLAG_WRITE, 15'h0003, 8'h00, 8'h00},
      {`OP_FLAG_READ, 15'h0003, 8'h00, 8'h00}, {`OP_FLAG_WRITE, 15'h0003, 8'h01, 8'h00},
      {`OP_FLAG_READ, 15'h0003, 8'h00, 8'h01}};
   dpram_port_ctl uut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_op(i_op),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_busy_wait(i_busy_wait), .o_ready(o_ready),
      .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_done(o_done), .o_chip_sel_n(o_chip_sel_n),
      .o_flag_select_n(o_flag_select_n), .o_rw_n(o_rw_n), .o_out_en_n(o_out_en_n),
      .o_addr(o_addr), .i_data(dev_q), .o_data(o_data), .o_data_oe(o_data_oe));
   dpram_port_model dev (.i_clk(i_clk), .i_cs_n(o_chip_sel_n), .i_flag_n(o_flag_select_n),
      .i_rw_n(o_rw_n), .i_oe_n(o_out_en_n), .i_addr(o_addr), .i_wd(wd), .o_q(dev_q));
   task check(input logic [31:0] s, input logic [31:0] e);
      begin
         n_checks = n_checks + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected t=%0t seen=%h expected=%h", $time, s, e);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks=%0d mismatches=%0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // outputs are read right after the edge, before that edge's updates land
   task run(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
      begin
         i_req <= 1'b1;
         i_op <= op;
         i_addr <= a;
         i_wdata <= d;
         cyc = 0;
         @(posedge i_clk);
         while (o_ready !== 1'b1 && cyc < 40) begin
            cyc = cyc + 1;
            @(posedge i_clk);
         end
         i_req <= 1'b0;
         do begin
            cyc = cyc + 1;
            @(posedge i_clk);
         end while (o_rvalid !== 1'b1 && o_done !== 1'b1 && cyc < 60);
         check(cyc < 60, 1);
      end
   endtask
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   initial begin
      #20000;
      bad_count = bad_count + 1;
      stop_test;
   end
   // =======
   // main sequence
   initial begin
      {i_rst, i_req, i_busy_wait, i_op, i_addr, i_wdata} = {3'h4, 25'h0};
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         run(rows[i][32:31], rows[i][30:16], rows[i][15:8]);
         if (!rows[i][31]) check(o_rdata, rows[i][7:0]);
      end
      i_busy_wait <= 1'b1;
      fork
         begin
            repeat (10) @(posedge i_clk);
            i_busy_wait <= 1'b0;
         end
         run(`OP_RAM_READ, 15'h0001, 8'h00);
      join
      check(cyc > 10, 1);
      check(o_rdata, 8'h5a);
      i_req <= 1'b1;
      i_op <= `OP_RAM_WRITE;
      i_addr <= 15'h0002;
      // reset lands inside the write pulse
      repeat (5) @(posedge i_clk);
      i_req <= 1'b0;
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      check({o_chip_sel_n, o_flag_select_n, o_rw_n, o_out_en_n, o_data_oe, o_ready}, 6'h3d);
      i_rst <= 1'b0;
      run(`OP_RAM_READ, 15'h7fff, 8'h00);
      check(o_rdata, 8'ha5);
      stop_test;
   end
endmodule // dual_port_ram_write_cycle_tb_top
`default_nettype wire
